//--- rtl/slsink_crc_tx.v
// running crc-32 of the outgoing words, with a test path that corrupts it
// assumes words arrive on a one-cycle valid strobe in the same clock
`timescale 1ns/1ps
`include "slsink_defines.vh"

module slsink_crc_tx (
  input  wire                       clk_i,      // system clock
  input  wire                       rst_i,      // synchronous reset, active high
  input  wire                       start_i,    // restart the crc (first word of burst)
  input  wire                       valid_i,    // word strobe
  input  wire [`SLSINK_WORD_W-1:0]  word_i,     // outgoing word
  input  wire                       inject_i,   // corrupt the crc while high
  output reg  [31:0]                crc_o       // crc sent with the word
);

  reg [31:0] crc_ff;  // running crc, uncorrupted

  // crc-32 over one 64-bit word, lsb first
  function [31:0] slsink_crc64;
    input [31:0] seed;
    input [`SLSINK_WORD_W-1:0] d;
    integer i;
    reg [31:0] c;
    begin
      c = seed;
      for (i = 0; i < `SLSINK_WORD_W; i = i + 1) begin
        if (c[0] ^ d[i]) begin
          c = (c >> 1) ^ `SLSINK_CRC_POLY;
        end else begin
          c = c >> 1;
        end
      end
      slsink_crc64 = c;
    end
  endfunction

  // advance crc and drive the sent value
  always @(posedge clk_i) begin
    if (rst_i) begin
      crc_ff <= `SLSINK_CRC_INIT;
      crc_o  <= 32'h00000000;
    end else if (valid_i) begin
      crc_ff <= slsink_crc64(start_i ? `SLSINK_CRC_INIT : crc_ff, word_i);
      // R19 corrupt sent crc
      crc_o  <= slsink_crc64(start_i ? `SLSINK_CRC_INIT : crc_ff, word_i)
                ^ (inject_i ? `SLSINK_CRC_FLIP : 32'h00000000);
    end
  end

endmodule

//--- rtl/slsink_defines.vh
// constants for the streaming link sink interface: register map, fields, reset values, timing
// assumes a 125 MHz system clock and a fixed lane count
`ifndef SLSINK_DEFINES_VH
`define SLSINK_DEFINES_VH

// lane count and derived widths
`define SLSINK_LANES        4
`define SLSINK_WORD_W       64
`define SLSINK_DATA_W       256
`define SLSINK_SYNC_W       8
`define SLSINK_ERR_W        9

// clock and reset sequence timing
`define SLSINK_CLK_MHZ      125
`define SLSINK_RSTSEQ_NS    64
`define SLSINK_RSTSEQ_CYC   ((`SLSINK_RSTSEQ_NS * `SLSINK_CLK_MHZ + 999) / 1000)
`define SLSINK_RSTCNT_W     8

// register byte offsets (word index times four)
`define SLSINK_ADDR_W       4
`define SLSINK_OFF_CTRL     4'h0
`define SLSINK_OFF_STATUS   4'h4
`define SLSINK_OFF_ERR      4'h8

// control register fields
`define SLSINK_CTRL_ADV     0
`define SLSINK_CTRL_ECC     1
`define SLSINK_CTRL_BURST   2
`define SLSINK_CTRL_RESET   3'h4

// status register fields
`define SLSINK_ST_LINKUP    0
`define SLSINK_ST_RSTBUSY   1
`define SLSINK_ST_STARTED   2

// error vector fields, relative to the lane count
`define SLSINK_ERR_ALIGN    (`SLSINK_LANES)
`define SLSINK_ERR_ZERO     (`SLSINK_LANES + 1)
`define SLSINK_ERR_OVF      (`SLSINK_LANES + 2)
`define SLSINK_ERR_CORR     (`SLSINK_LANES + 3)
`define SLSINK_ERR_UNCORR   (`SLSINK_LANES + 4)

// crc-32 constants, reflected form
`define SLSINK_CRC_POLY     32'hEDB88320
`define SLSINK_CRC_INIT     32'hFFFFFFFF
`define SLSINK_CRC_FLIP     32'h00000001

`endif

//--- rtl/slsink_top.v
// receive-side user interface of a multi-lane streaming link
// assumes a link layer delivering aligned lane words and error strobes, all synchronous to clk_i
//
// Function
// R01 - standard mode: own sink clock times transfers
// R02 - advanced mode: core-domain clock output times transfers
// R03 - standard mode: sink reset follows master reset
// R04 - advanced mode: core reset follows master reset
// R05 - link ready only after initialization complete
// R06 - consumer ignores words while link down
// R07 - payload sixty-four bits per lane
// R08 - eight-bit sideband from remote partner
// R09 - end sideband counts invalid words last cycle
// R10 - word valid marks every valid data cycle
// R11 - burst mode: first flag opens burst
// R12 - continuous mode: first flag only once
// R13 - burst mode: last flag closes burst
// R14 - optional end marker shown in continuous
// R15 - error vector lanes plus five, ecc bits
// R16 - fifo overflow bit in standard mode
// R17 - zero bit, alignment bit, lane crc bits
// R18 - single-bit crc error injection input
// R19 - injection corrupts outgoing crc-32
// R20 - master reset resets link layer
//
// The implementer's own choices: the register addresses and the Wishbone slave port.
`timescale 1ns/1ps
`include "slsink_defines.vh"

module slsink_top (
  input  wire                        clk_i,              // system clock, 125 MHz
  input  wire                        rst_i,              // synchronous reset, active high
  // wishbone classic slave
  input  wire                        wb_cyc_i,           // bus cycle
  input  wire                        wb_stb_i,           // strobe
  input  wire                        wb_we_i,            // write enable
  input  wire [`SLSINK_ADDR_W-1:0]   wb_adr_i,           // byte address
  input  wire [3:0]                  wb_sel_i,           // byte lanes
  input  wire [31:0]                 wb_dat_i,           // write data
  output reg  [31:0]                 wb_dat_o,           // read data
  output reg                         wb_ack_o,           // acknowledge
  // master reset and link layer side
  input  wire                        core_reset_i,       // master reset, active high
  input  wire                        lane_init_done_i,   // lanes locked and aligned
  input  wire                        lane_valid_i,       // recovered word valid
  input  wire [`SLSINK_DATA_W-1:0]   lane_data_i,        // recovered words, lane 0 lowest
  input  wire [`SLSINK_SYNC_W-1:0]   lane_sync_i,        // sideband from remote partner
  input  wire                        lane_first_i,       // burst opens with this word
  input  wire                        lane_last_i,        // burst closes with this word
  input  wire [`SLSINK_LANES-1:0]    lane_crc_err_i,     // per-lane crc-32 error strobes
  input  wire                        lane_align_lost_i,  // alignment lost
  input  wire                        fifo_ovf_i,         // adaptation fifo overflow
  input  wire                        seu_corr_i,         // corrected upset
  input  wire                        seu_uncorr_i,       // uncorrectable upset
  output reg                         lane_take_o,        // word sampled last cycle
  // transmit test path
  input  wire                        tx_valid_i,         // outgoing word strobe
  input  wire                        tx_first_i,         // outgoing burst start
  input  wire [`SLSINK_WORD_W-1:0]   tx_word_i,          // outgoing word
  input  wire                        crc_error_inject_i, // corrupt outgoing crc
  output wire [31:0]                 tx_crc_o,           // crc sent with the word
  // sink user interface
  output reg                         sink_clk_o,         // standard mode interface clock
  output reg                         sink_rst_o,         // standard mode interface reset
  output reg                         core_if_clk_o,      // advanced mode interface clock
  output reg                         core_if_rst_o,      // advanced mode interface reset
  output reg                         sink_link_up_o,     // link ready
  output reg  [`SLSINK_DATA_W-1:0]   sink_data_o,        // received payload
  output reg  [`SLSINK_SYNC_W-1:0]   sink_sync_o,        // sideband value
  output reg                         sink_valid_o,       // word valid
  output reg                         sink_burst_first_o, // burst opens
  output reg                         sink_burst_last_o,  // burst closes
  output reg  [`SLSINK_ERR_W-1:0]    sink_error_o        // error vector
);

  // control and state registers
  reg [2:0]                   ctrl_ff;       // adv, ecc, burst
  reg [`SLSINK_ERR_W-1:0]     err_sticky_ff; // sticky copy of the error vector
  reg                         div_ff;        // interface clock phase
  reg [`SLSINK_RSTCNT_W-1:0]  rstcnt_ff;     // reset sequence counter
  reg                         started_ff;    // continuous stream has begun

  // reset sequence state, one-hot
  localparam ST_HOLD = 3'b001;               // master reset high
  localparam ST_SEQ  = 3'b010;               // sequence running
  localparam ST_DONE = 3'b100;               // interface released
  reg [2:0] state_ff;                        // current state
  reg [2:0] nxt_state;                       // next state

  // decoded helpers
  wire adv_mode   = ctrl_ff[`SLSINK_CTRL_ADV];
  wire ecc_en     = ctrl_ff[`SLSINK_CTRL_ECC];
  wire burst_mode = ctrl_ff[`SLSINK_CTRL_BURST];
  wire tick       = div_ff;                  // last cycle of an interface clock high phase
  wire wb_req     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  // writes land on the edge at which the master samples ack, with the request still held
  wire wb_wr      = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
  wire seq_busy   = ~state_ff[2];
  wire link_ok    = state_ff[2] & lane_init_done_i & ~lane_align_lost_i;

  // error vector assembled from this cycle's events
  // don't-care bits are driven zero so a stale value never reads as an event
  reg [`SLSINK_ERR_W-1:0] nxt_err;           // live error vector

  // R15 ecc upset bits
  // R16 overflow bit
  // R17 zero, alignment, crc bits
  always @* begin
    nxt_err = {`SLSINK_ERR_W{1'b0}};
    nxt_err[`SLSINK_LANES-1:0]   = lane_crc_err_i;
    nxt_err[`SLSINK_ERR_ALIGN]   = lane_align_lost_i;
    nxt_err[`SLSINK_ERR_ZERO]    = 1'b0;
    nxt_err[`SLSINK_ERR_OVF]     = fifo_ovf_i & ~adv_mode;
    nxt_err[`SLSINK_ERR_CORR]    = seu_corr_i & ecc_en & ~adv_mode;
    nxt_err[`SLSINK_ERR_UNCORR]  = seu_uncorr_i & ecc_en & ~adv_mode;
  end

  // reset sequence next state
  // R20 master reset restarts
  always @* begin
    case (state_ff)
      ST_HOLD: begin
        nxt_state = core_reset_i ? ST_HOLD : ST_SEQ;
      end
      ST_SEQ: begin
        if (core_reset_i) begin
          nxt_state = ST_HOLD;
        end else if (rstcnt_ff == (`SLSINK_RSTSEQ_CYC - 1)) begin
          nxt_state = ST_DONE;
        end else begin
          nxt_state = ST_SEQ;
        end
      end
      ST_DONE: begin
        nxt_state = core_reset_i ? ST_HOLD : ST_DONE;
      end
      default: begin
        nxt_state = ST_HOLD;
      end
    endcase
  end

  // reset sequence state and counter
  // the counter is cleared outside the sequence so a second master reset restarts it
  always @(posedge clk_i) begin
    if (rst_i) begin
      state_ff  <= ST_HOLD;
      rstcnt_ff <= {`SLSINK_RSTCNT_W{1'b0}};
    end else begin
      state_ff <= nxt_state;
      // count only while the sequence runs
      if (state_ff == ST_SEQ) begin
        rstcnt_ff <= rstcnt_ff + 1'b1;
      end else begin
        rstcnt_ff <= {`SLSINK_RSTCNT_W{1'b0}};
      end
    end
  end

  // interface clocks: half rate, only the selected mode's clock runs
  // the idle mode's clock is parked low so its consumer sees no stray edges
  always @(posedge clk_i) begin
    if (rst_i) begin
      div_ff        <= 1'b0;
      sink_clk_o    <= 1'b0;
      core_if_clk_o <= 1'b0;
    end else begin
      div_ff        <= ~div_ff;
      // R01 standard clock output
      sink_clk_o    <= ~div_ff & ~adv_mode;
      // R02 advanced clock output
      core_if_clk_o <= ~div_ff & adv_mode;
    end
  end

  // interface resets follow the sequence, each only in its mode
  always @(posedge clk_i) begin
    if (rst_i) begin
      sink_rst_o    <= 1'b1;
      core_if_rst_o <= 1'b1;
    end else begin
      // R03 standard mode reset
      sink_rst_o    <= (seq_busy | core_reset_i) & ~adv_mode;
      // R04 advanced mode reset
      core_if_rst_o <= (seq_busy | core_reset_i) & adv_mode;
    end
  end

  // sink stream outputs, updated once per interface clock on its falling edge
  // holding them across the rising edge gives the consumer half a period of setup and hold
  always @(posedge clk_i) begin
    if (rst_i || core_reset_i) begin
      sink_link_up_o     <= 1'b0;
      sink_data_o        <= {`SLSINK_DATA_W{1'b0}};
      sink_sync_o        <= {`SLSINK_SYNC_W{1'b0}};
      sink_valid_o       <= 1'b0;
      sink_burst_first_o <= 1'b0;
      sink_burst_last_o  <= 1'b0;
      sink_error_o       <= {`SLSINK_ERR_W{1'b0}};
      started_ff         <= 1'b0;
      lane_take_o        <= 1'b0;
    end else begin
      lane_take_o <= tick & lane_valid_i;
      if (tick) begin
        // R05 ready after initialization
        sink_link_up_o <= link_ok;
        sink_error_o   <= nxt_err;
        // R10 valid every data cycle
        sink_valid_o   <= lane_valid_i;
        if (lane_valid_i) begin
          // R07 full width payload
          sink_data_o <= lane_data_i;
          // R08 sideband captured at burst edges
          // R09 end value passed untouched
          if (lane_first_i || lane_last_i) begin
            sink_sync_o <= lane_sync_i;
          end
          if (burst_mode) begin
            // R11 burst opens
            sink_burst_first_o <= lane_first_i;
          end else begin
            // R12 continuous opens once
            sink_burst_first_o <= lane_first_i & ~started_ff;
          end
          // R13 burst closes
          // R14 optional continuous end
          sink_burst_last_o <= lane_last_i;
          // a last word rearms the continuous first flag; burst mode keeps it clear
          if (burst_mode || lane_last_i) begin
            started_ff <= 1'b0;
          end else if (lane_first_i) begin
            started_ff <= 1'b1;
          end
        end else begin
          // flags never linger on a non-valid cycle
          sink_burst_first_o <= 1'b0;
          sink_burst_last_o  <= 1'b0;
        end
      end
    end
  end

  // the test path runs beside the sink logic and shares only clock and reset
  // R18 crc injection path
  // R19 corrupted outgoing crc
  slsink_crc_tx slsink_crc_tx_i (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .start_i  (tx_first_i),
    .valid_i  (tx_valid_i),
    .word_i   (tx_word_i),
    .inject_i (crc_error_inject_i),
    .crc_o    (tx_crc_o)
  );

  // register writes and sticky error capture; new events win over clearing
  always @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_ff       <= `SLSINK_CTRL_RESET;
      err_sticky_ff <= {`SLSINK_ERR_W{1'b0}};
    end else begin
      // control register, low byte lane
      if (wb_wr && wb_sel_i[0] && wb_adr_i == `SLSINK_OFF_CTRL) begin
        ctrl_ff <= wb_dat_i[2:0];
      end
      // write one to clear, set wins
      if (wb_wr && wb_adr_i == `SLSINK_OFF_ERR) begin
        err_sticky_ff <= (err_sticky_ff & ~(wb_dat_i[`SLSINK_ERR_W-1:0]
                         & {{(`SLSINK_ERR_W-8){wb_sel_i[1]}}, {8{wb_sel_i[0]}}})) | nxt_err;
      end else begin
        err_sticky_ff <= err_sticky_ff | nxt_err;
      end
    end
  end

  // wishbone answer: ack one cycle after the request, dropped the next cycle
  // read data stays zero outside the ack cycle so a shared bus needs no gating
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= 32'h00000000;
      if (wb_req && !wb_we_i) begin
        case (wb_adr_i)
          `SLSINK_OFF_CTRL: begin
            wb_dat_o <= {29'h0000000, ctrl_ff};
          end
          `SLSINK_OFF_STATUS: begin
            wb_dat_o <= {29'h0000000, started_ff, seq_busy, sink_link_up_o};
          end
          `SLSINK_OFF_ERR: begin
            wb_dat_o <= {{(32-`SLSINK_ERR_W){1'b0}}, err_sticky_ff};
          end
          default: begin
            // unmapped reads as zero
            wb_dat_o <= 32'h00000000;
          end
        endcase
      end
    end
  end

endmodule

//--- tb/slsink_partner.sv
// consumer model: counts words taken at the interface clock rising edge
// assumes only one of the two interface clocks runs at a time
`timescale 1ns/1ps
`include "slsink_defines.vh"
module slsink_partner (
  input  wire                      if_clk_i,  // clock of the active mode
  input  wire                      link_up_i, // link ready
  input  wire                      valid_i,   // word valid
  input  wire [`SLSINK_DATA_W-1:0] data_i,    // payload
  output reg  [15:0]               words_o,   // words accepted
  output reg  [`SLSINK_DATA_W-1:0] last_o     // last word accepted
);
  initial begin
    words_o = 16'h0000;
    last_o = '0;
  end
  always @(posedge if_clk_i) begin
    if (link_up_i && valid_i) begin
      words_o <= words_o + 16'h0001;
      last_o <= data_i;
    end
  end
endmodule

//--- tb/slsink_props.sv
// checker: bus handshake, stream timing, resets, error vector
// assumes it is bound to slsink_top, one clock, rst_i synchronous
`timescale 1ns/1ps
`include "slsink_defines.vh"
module slsink_props (
  input wire                      clk_i,
  input wire                      rst_i,
  input wire                      wb_cyc_i,
  input wire                      wb_stb_i,
  input wire                      wb_ack_o,
  input wire [31:0]               wb_dat_o,
  input wire                      core_reset_i,
  input wire                      lane_init_done_i,
  input wire                      lane_valid_i,
  input wire [`SLSINK_DATA_W-1:0] lane_data_i,
  input wire                      lane_take_o,
  input wire                      sink_clk_o,
  input wire                      core_if_clk_o,
  input wire                      sink_rst_o,
  input wire                      core_if_rst_o,
  input wire                      sink_link_up_o,
  input wire [`SLSINK_DATA_W-1:0] sink_data_o,
  input wire                      sink_valid_o,
  input wire                      sink_burst_first_o,
  input wire                      sink_burst_last_o,
  input wire [`SLSINK_ERR_W-1:0]  sink_error_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // bus answers one cycle after the request, for one cycle
  a_ack_next_cycle: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not acknowledged");
  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
  a_dat_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("read data outside ack");
  a_clk_one_mode: assert property (!(sink_clk_o && core_if_clk_o))
    else $error("both interface clocks high");
  // stream outputs never move on the interface rising edge, except when a master reset clears them
  a_stream_stable: assert property ($rose(sink_clk_o) && !$past(core_reset_i) |-> $stable(sink_data_o)
    && $stable(sink_valid_o)) else $error("stream changed at interface rising edge");
  a_core_rst_out: assert property (core_reset_i |=> (sink_rst_o != core_if_rst_o) && !sink_valid_o
    && !sink_link_up_o) else $error("master reset not followed");
  a_link_after_init: assert property ($rose(sink_link_up_o) |-> $past(lane_init_done_i)
    && !sink_rst_o && !core_if_rst_o) else $error("link up before initialization");
  a_take_data: assert property (lane_take_o |-> sink_valid_o && $past(lane_valid_i)
    && sink_data_o == $past(lane_data_i)) else $error("taken word not presented");
  a_marks_valid: assert property (sink_burst_first_o || sink_burst_last_o |-> sink_valid_o)
    else $error("burst mark without valid word");
  a_err_zero_bit: assert property (sink_error_o[`SLSINK_ERR_ZERO] == 1'b0)
    else $error("error bit above alignment not zero");
  c_link_up: cover property ($rose(sink_link_up_o));
  c_first: cover property (sink_burst_first_o && lane_take_o);
  c_last: cover property (sink_burst_last_o && lane_take_o);
  c_error: cover property (sink_error_o != 9'h000);
endmodule

//--- tb/slsink_top_tb.sv
// bench: registers, burst and continuous stream, error vector, resets, crc test path
// assumes slsink_top, slsink_props and slsink_partner are compiled alongside
`timescale 1ns/1ps
`include "slsink_defines.vh"
module slsink_top_tb;
  reg                       clk_i = 1'b0, rst_i = 1'b1, core_reset_i = 1'b0, lane_init_done_i = 1'b0;
  reg                       wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  reg  [3:0]                wb_adr_i = 4'h0, wb_sel_i = 4'h0, lane_crc_err_i = 4'h0;
  reg  [31:0]               wb_dat_i = 32'h0;
  reg                       lane_valid_i = 1'b0, lane_first_i = 1'b0, lane_last_i = 1'b0;
  reg  [`SLSINK_DATA_W-1:0] lane_data_i = '0;
  reg  [7:0]                lane_sync_i = 8'h00;
  reg                       lane_align_lost_i = 1'b0, fifo_ovf_i = 1'b0, seu_corr_i = 1'b0, seu_uncorr_i = 1'b0;
  reg                       tx_valid_i = 1'b0, tx_first_i = 1'b0, crc_error_inject_i = 1'b0;
  reg  [63:0]               tx_word_i = 64'h0;  // outgoing word for the crc test path
  wire                      wb_ack_o, lane_take_o, sink_clk_o, sink_rst_o, core_if_clk_o, core_if_rst_o;
  wire                      sink_link_up_o, sink_valid_o, sink_burst_first_o, sink_burst_last_o;
  wire [31:0]               wb_dat_o, tx_crc_o;
  wire [`SLSINK_DATA_W-1:0] sink_data_o, p_last;
  wire [7:0]                sink_sync_o;
  wire [8:0]                sink_error_o;
  wire [15:0]               p_words;
  integer                   error_cnt = 0, n_checks = 0;
  reg  [31:0]               rd;
  slsink_top slsink_top_i (.*);
  slsink_partner slsink_partner_i (.if_clk_i(sink_clk_o | core_if_clk_o), .link_up_i(sink_link_up_o),
    .valid_i(sink_valid_o), .data_i(sink_data_o), .words_o(p_words), .last_o(p_last));
  always #4 clk_i = ~clk_i;
  task automatic check(input string what, input logic [255:0] seen, input logic [255:0] exp);
    n_checks = n_checks + 1;
    if (seen !== exp) begin
      error_cnt = error_cnt + 1;
      $display("ERROR %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  // classic single cycle, held until ack is sampled
  task automatic wb(input logic we, input logic [3:0] adr, input logic [3:0] sel, input logic [31:0] wd);
    integer k;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= sel;
    wb_dat_i <= wd;
    for (k = 0; k < 20; k = k + 1) begin
      @(posedge clk_i);
      if (wb_ack_o === 1'b1) break;
    end
    check("bus ack", k < 20, 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  // holds one word until the block reports it taken
  task automatic send(input logic [255:0] d, input logic [7:0] s, input logic f, input logic l);
    integer k;
    // one edge passes after the previous release, so valid is never driven twice in a step
    @(posedge clk_i);
    lane_valid_i <= 1'b1;
    lane_data_i <= d;
    lane_sync_i <= s;
    lane_first_i <= f;
    lane_last_i <= l;
    for (k = 0; k < 10; k = k + 1) begin
      @(posedge clk_i);
      if (lane_take_o === 1'b1) break;
    end
    check("data", sink_data_o, d);
    check("valid", sink_valid_o, 1'b1);
    lane_valid_i <= 1'b0;
  endtask
  // outputs that wait_sig can poll: 0 link up, 1 sink reset
  wire [1:0]                watch = {sink_rst_o, sink_link_up_o};
  task automatic wait_sig(input string what, input integer idx, input logic lvl);
    integer k;
    for (k = 0; k < 60 && watch[idx] !== lvl; k = k + 1) @(posedge clk_i);
    check(what, watch[idx], lvl);
  endtask
  task automatic set_events(input logic on);
    lane_crc_err_i <= on ? 4'hA : 4'h0;
    {lane_align_lost_i, fifo_ovf_i, seu_corr_i, seu_uncorr_i} <= {4{on}};
    repeat (4) @(posedge clk_i);
  endtask
  task automatic t_burst();
    send({32{8'hA5}}, 8'h5A, 1'b1, 1'b0);
    check("first", sink_burst_first_o, 1'b1);
    check("sync", sink_sync_o, 8'h5A);
    send({32{8'h3C}}, 8'h11, 1'b0, 1'b0);
    check("sync held", sink_sync_o, 8'h5A);
    check("first", sink_burst_first_o, 1'b0);
    send({32{8'hF0}}, 8'h03, 1'b0, 1'b1);
    check("last", sink_burst_last_o, 1'b1);
    check("sync end", sink_sync_o, 8'h03);
  endtask
  task automatic t_cont();
    wb(1'b1, 4'h0, 4'h1, 32'h0);
    send({16{16'h1234}}, 8'h00, 1'b1, 1'b0);
    check("first", sink_burst_first_o, 1'b1);
    send({16{16'h5678}}, 8'h00, 1'b1, 1'b0);
    check("first again", sink_burst_first_o, 1'b0);
    send({16{16'h9ABC}}, 8'h00, 1'b0, 1'b1);
    check("end marker", sink_burst_last_o, 1'b1);
  endtask
  task automatic t_err();
    wb(1'b1, 4'h0, 4'h1, 32'h6);
    set_events(1'b1);
    check("error std", sink_error_o, 9'h1DA);
    check("link on align loss", sink_link_up_o, 1'b0);
    set_events(1'b0);
    wb(1'b0, 4'h8, 4'hF, 32'h0);
    check("sticky err", rd, 32'h1DA);
    wb(1'b1, 4'h8, 4'h3, 32'h1FF);
    wb(1'b0, 4'h8, 4'hF, 32'h0);
    check("err cleared", rd, 32'h0);
    wb(1'b1, 4'h0, 4'h1, 32'h7);
    set_events(1'b1);
    check("error adv", sink_error_o, 9'h01A);
    rd[0] = core_if_clk_o;
    @(posedge clk_i);
    check("adv clock runs", core_if_clk_o ^ rd[0], 1'b1);
    check("std clock still", sink_clk_o, 1'b0);
    set_events(1'b0);
    wb(1'b1, 4'h0, 4'h1, 32'h4);
    wait_sig("link back", 0, 1'b1);
  endtask
  task automatic t_resets();
    core_reset_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    check("sink reset", sink_rst_o, 1'b1);
    check("core if reset", core_if_rst_o, 1'b0);
    core_reset_i <= 1'b0;
    wait_sig("sink reset end", 1, 1'b0);
    wait_sig("link after reset", 0, 1'b1);
  endtask
  task automatic t_crc();
    // the same opening word each cycle, so the sent crc only moves with injection
    tx_word_i <= 64'h0123456789ABCDEF;
    tx_first_i <= 1'b1;
    tx_valid_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rd = tx_crc_o;
    crc_error_inject_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    check("crc flip", tx_crc_o ^ rd, 32'h1);
    crc_error_inject_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    check("crc restored", tx_crc_o ^ rd, 32'h0);
    tx_valid_i <= 1'b0;
    tx_first_i <= 1'b0;
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, 4'h0, 4'hF, 32'h0);
    check("ctrl reset", rd, 32'h4);
    wb(1'b0, 4'hC, 4'hF, 32'h0);
    check("unmapped", rd, 32'h0);
    lane_init_done_i <= 1'b1;
    wait_sig("link up", 0, 1'b1);
    wb(1'b0, 4'h4, 4'hF, 32'h0);
    check("status", rd, 32'h1);
    t_burst();
    t_cont();
    t_err();
    t_resets();
    t_crc();
    check("consumer count", p_words, 16'd6);
    end_of_test();
  end
  initial begin
    #40000;
    error_cnt = error_cnt + 1;
    end_of_test();
  end
endmodule
bind slsink_top slsink_props slsink_props_i (.*);
